// ==== logic/isp_access.sv ====
// Serial programming access to flash, EEPROM and locks; parallel readout of fuses, locks and signature
`timescale 1ns/1ns
module isp_access
  import isp_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES  = BUSY_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_WAIT_CYC,
  parameter int unsigned WRITE_CYCLES = WRITE_WAIT_CYC,
  parameter logic [7:0]  SIG0         = 8'h1E, // Arbitrary value
  parameter logic [7:0]  SIG1         = 8'h90, // Arbitrary value
  parameter logic [7:0]  SIG2         = 8'h01  // Arbitrary value
) (
  input  wire logic       CLK,          // System clock
  input  wire logic       NRST,         // Async reset, active low
  input  wire logic       RESET_PIN,    // Device reset pin level
  input  wire logic       SCK,          // Serial clock
  input  wire logic       MOSI,         // Serial data in
  output logic            MISO,         // Serial data out
  input  wire logic       OE_N,         // Parallel output enable, low
  input  wire logic       WR_N,         // Parallel write strobe, low
  input  wire logic       BYTE_HALF_SELECT, // Byte select
  input  wire logic       XA_LOAD,      // Parallel command or address load pulse
  input  wire logic [7:0] DATA_IN,      // Parallel data bus in
  output logic [7:0]      DATA_OUT,     // Parallel data bus out
  output logic            DATA_OE,      // Parallel data drive enable
  output logic            READY_NOT_WORKING, // High when ready
  input  wire logic       SERIAL_PROG_ENABLE_FUSE, // Fuse, 0 programmed
  input  wire logic       INTERNAL_RC_SELECT_FUSE, // Fuse, 0 programmed
  output logic            PROG_ENABLED  // Serial programming enabled
);
  logic [7:0]  flash_mem [FLASH_WORDS*2];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [7:0]  next_flash_mem [FLASH_WORDS*2];
  logic [7:0]  next_ee_mem    [EE_BYTES];
  logic [1:0]  lock, next_lock;
  // Synchronisers
  logic [1:0] s_sck, s_mosi, s_rst, s_oe, s_wr, s_bs, s_xa;
  logic       sck_d, wr_d, xa_d;
  logic [15:0] s_din;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_sck <= 2'h0; s_mosi <= 2'h0; s_rst <= 2'h3; s_oe <= 2'h3;
      s_wr  <= 2'h3; s_bs <= 2'h0; s_xa <= 2'h0;
      sck_d <= 1'b0; wr_d <= 1'b1; xa_d <= 1'b0;
      s_din <= 16'h0000;
    end else begin
      s_sck <= {s_sck[0], SCK};
      s_mosi <= {s_mosi[0], MOSI};
      s_rst <= {s_rst[0], RESET_PIN};
      s_oe <= {s_oe[0], OE_N};
      s_wr <= {s_wr[0], WR_N};
      s_bs <= {s_bs[0], BYTE_HALF_SELECT};
      s_xa <= {s_xa[0], XA_LOAD};
      sck_d <= s_sck[1];
      wr_d <= s_wr[1];
      xa_d <= s_xa[1];
      s_din <= {s_din[7:0], DATA_IN};
    end
  end
  wire sck_rise = s_sck[1] & ~sck_d;
  wire sck_fall = ~s_sck[1] & sck_d;
  wire rst_low  = ~s_rst[1];

  // Serial shift state
  logic [31:0] shin, next_shin;
  logic [5:0]  bitcnt, next_bitcnt;
  logic [7:0]  shout, next_shout;
  logic        miso, next_miso, en, next_en;
  // Write engine
  isp_wst_e    wst, next_wst;
  logic [31:0] tmr, next_tmr;
  logic        wr_ee, next_wr_ee;
  logic [9:0]  waddr, next_waddr;
  logic [7:0]  wdata, next_wdata;
  // Parallel side
  logic [7:0]  pcmd, next_pcmd, paddr, next_paddr;
  logic [31:0] btmr, next_btmr;
  logic        rdy, next_rdy;
  isp_bus_s    pbus, next_pbus;

  function automatic logic [7:0] sig_byte(input logic [1:0] a);
    unique case (a)
      2'h0:    sig_byte = SIG0;
      2'h1:    sig_byte = SIG1;
      2'h2:    sig_byte = SIG2;
      default: sig_byte = 8'h00;
    endcase
  endfunction

  // Polled value of a location under write
  function automatic logic [7:0] rd_val(input logic ee, input logic [9:0] a,
                                        input logic [7:0] v);
    rd_val = v;
    if (wst != ISP_IDLE && wst != ISP_ERASE && wr_ee == ee && waddr == a) begin
      if (ee)
        rd_val = (wst == ISP_AUTO) ? POLL_VALUE_FIRST
                                   : POLL_VALUE_SECOND;
      else
        rd_val = ERASED;
    end
  endfunction

  always_comb begin
    logic [31:0] f;
    logic        busy;
    f = {shin[30:0], s_mosi[1]};
    busy = (wst != ISP_IDLE);
    next_shin = shin;
    next_bitcnt = bitcnt;
    next_shout = shout;
    next_miso = miso;
    next_en = en;
    next_wst = wst;
    next_tmr = tmr;
    next_wr_ee = wr_ee;
    next_waddr = waddr;
    next_wdata = wdata;
    next_lock = lock;
    next_flash_mem = flash_mem;
    next_ee_mem = ee_mem;
    // Write timer: EEPROM erase half then program half
    if (wst != ISP_IDLE) begin
      if (tmr != 32'h0) begin
        next_tmr = tmr - 32'h1;
      end else begin
        unique case (wst)
          ISP_AUTO: begin
            next_wst = ISP_PROG;
            next_tmr = WRITE_CYCLES[31:0] >> 1;
            next_ee_mem[waddr[5:0]] = ERASED;
          end
          ISP_PROG: begin
            next_wst = ISP_IDLE;
            if (wr_ee) next_ee_mem[waddr[5:0]] = wdata;
            else next_flash_mem[waddr] = flash_mem[waddr] & wdata;
          end
          ISP_ERASE: begin
            next_wst = ISP_IDLE;
            for (int i = 0; i < FLASH_WORDS*2; i++)
              next_flash_mem[i] = ERASED;
            for (int i = 0; i < EE_BYTES; i++)
              next_ee_mem[i] = ERASED;
            next_lock = 2'h3;
          end
          default: next_wst = ISP_IDLE;
        endcase
      end
    end
    if (!rst_low) begin
      next_en = 1'b0;
      next_bitcnt = 6'h0;
      next_miso = 1'b0;
    end else if (sck_rise) begin
      next_shin = f;
      next_bitcnt = bitcnt + 6'h1;
      if (bitcnt == FRAME_BITS - 6'h9) begin // Byte 3 done: fetch
        next_shout = 8'h00;
        if (f[23:20] == OP_FL_RD && f[18:16] == 3'h0)
          next_shout = rd_val(1'b0, {f[8], f[7:0], f[19]},
                              flash_mem[{f[8], f[7:0], f[19]}]);
        else if (f[23:16] == OP_EE_RD)
          next_shout = rd_val(1'b1, {4'h0, f[5:0]}, ee_mem[f[5:0]]);
        else if (f[23:16] == OP_SIG_RD && lock != 2'h0)
          next_shout = sig_byte(f[1:0]);
      end
      if (bitcnt == FRAME_BITS - 6'h1) begin
        next_bitcnt = 6'h0;
        if (f[31:24] == OP_PRE && f[23:16] == OP_PROG_EN && SERIAL_PROG_ENABLE_FUSE == 1'b0)
          next_en = 1'b1;
        else if (en && !busy) begin
          if (f[31:24] == OP_PRE && f[23:21] == OP_ERASE_TOP) begin
            next_wst = ISP_ERASE;
            next_tmr = ERASE_CYCLES[31:0];
          end else if (f[31:24] == OP_PRE && (f[23:16] | 8'h06) == 8'hFF) begin
            next_lock = lock & {f[16+LOCK2_BIT], f[16+LOCK1_BIT]};
          end else if (f[31:28] == OP_FL_WR && f[26:24] == 3'h0
                       && f[23:17] == 7'h0) begin
            next_wst = ISP_PROG; next_wr_ee = 1'b0;
            next_waddr = {f[16], f[15:8], f[27]};
            next_wdata = f[7:0]; next_tmr = WRITE_CYCLES[31:0];
          end else if (f[31:24] == OP_EE_WR && f[15:14] == 2'h0) begin
            next_wst = ISP_AUTO; next_wr_ee = 1'b1;
            next_waddr = {4'h0, f[13:8]};
            next_wdata = f[7:0]; next_tmr = WRITE_CYCLES[31:0] >> 1;
          end
        end
      end
    end else if (sck_fall) begin
      if (bitcnt >= FRAME_BITS - 6'h8 || bitcnt == 6'h0) begin
        next_miso = shout[7];
        next_shout = {shout[6:0], 1'b0};
      end
    end
  end

  // Parallel readout and busy pulse
  always_comb begin
    next_pcmd = pcmd;
    next_paddr = paddr;
    next_btmr = btmr;
    next_rdy = rdy;
    next_pbus = '{data: 8'h00, oe: 1'b0};
    if (s_xa[1] & ~xa_d) begin
      if (s_bs[1]) next_paddr = s_din[15:8];
      else next_pcmd = s_din[15:8];
    end
    // Busy shows only once the strobe is back high; a long strobe hides it
    if (!s_wr[1] && wr_d) begin
      next_btmr = BUSY_CYCLES[31:0];
    end else if (btmr != 32'h0) begin
      next_btmr = btmr - 32'h1;
    end
    next_rdy = !(s_wr[1] && next_btmr != 32'h0);
    if (!s_oe[1]) begin
      if (pcmd == PCMD_FUSE_RD && s_bs[1]) begin
        next_pbus.oe = 1'b1;
        next_pbus.data = 8'hFF;
        next_pbus.data[POS_LB1] = lock[0];
        next_pbus.data[POS_LB2] = lock[1];
        next_pbus.data[POS_SPI_FUSE] = SERIAL_PROG_ENABLE_FUSE;
        next_pbus.data[POS_RC_FUSE] = INTERNAL_RC_SELECT_FUSE;
      end else if (pcmd == PCMD_SIG_RD && !s_bs[1]
                   && paddr <= 8'h02) begin
        next_pbus.oe = 1'b1;
        next_pbus.data = sig_byte(paddr[1:0]);
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      shin <= 32'h0; bitcnt <= 6'h0; shout <= 8'h00; miso <= 1'b0;
      en <= 1'b0; wst <= ISP_IDLE; tmr <= 32'h0; wr_ee <= 1'b0;
      waddr <= 10'h0; wdata <= 8'h00; lock <= 2'h3;
      pcmd <= 8'h00; paddr <= 8'h00; btmr <= 32'h0; rdy <= 1'b1;
      pbus <= '{data: 8'h00, oe: 1'b0};
      for (int i = 0; i < FLASH_WORDS*2; i++) flash_mem[i] <= ERASED;
      for (int i = 0; i < EE_BYTES; i++) ee_mem[i] <= ERASED;
    end else begin
      shin <= next_shin; bitcnt <= next_bitcnt; shout <= next_shout;
      miso <= next_miso; en <= next_en; wst <= next_wst; tmr <= next_tmr;
      wr_ee <= next_wr_ee; waddr <= next_waddr; wdata <= next_wdata;
      lock <= next_lock; pcmd <= next_pcmd; paddr <= next_paddr;
      btmr <= next_btmr; rdy <= next_rdy; pbus <= next_pbus;
      flash_mem <= next_flash_mem; ee_mem <= next_ee_mem;
    end
  end

  assign MISO = miso;
  assign DATA_OUT = pbus.data;
  assign DATA_OE = pbus.oe;
  assign READY_NOT_WORKING = rdy;
  assign PROG_ENABLED = en;
endmodule

// ==== logic/isp_pkg.sv ====
// Constants and types for the serial and parallel programming access block
package isp_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned FLASH_WORDS    = 512;
  localparam int unsigned EE_BYTES       = 64;
  localparam logic [8:0]  FLASH_MAX_ADDR = 9'h1FF;
  localparam logic [5:0]  EE_MAX_ADDR    = 6'h3F;
  // Serial opcodes
  localparam logic [7:0] OP_PRE         = 8'hAC;
  localparam logic [7:0] OP_PROG_EN     = 8'h53;
  localparam logic [2:0] OP_ERASE_TOP   = 3'h4;
  localparam logic [3:0] OP_FL_RD       = 4'h2;
  localparam logic [3:0] OP_FL_WR       = 4'h4;
  localparam logic [7:0] OP_EE_RD       = 8'hA0;
  localparam logic [7:0] OP_EE_WR       = 8'hC0;
  localparam logic [7:0] OP_SIG_RD      = 8'h30;
  localparam logic [7:0] LOCK_MASK      = 8'hF9;
  // Parallel command bytes
  localparam logic [7:0] PCMD_FUSE_RD   = 8'h04;
  localparam logic [7:0] PCMD_SIG_RD    = 8'h08;
  // Fuse and lock positions in the parallel readout byte and the serial lock write byte
  localparam int unsigned POS_LB1       = 7;
  localparam int unsigned POS_LB2       = 6;
  localparam int unsigned POS_SPI_FUSE  = 5;
  localparam int unsigned POS_RC_FUSE   = 0;
  localparam int unsigned LOCK1_BIT     = 1;
  localparam int unsigned LOCK2_BIT     = 2;
  localparam logic [7:0] POLL_VALUE_FIRST  = 8'h00;
  localparam logic [7:0] POLL_VALUE_SECOND = 8'hFF;
  localparam logic [7:0] ERASED          = 8'hFF;
  // Timing, in microseconds and clock cycles
  localparam int unsigned BUSY_MIN_US    = 500;
  localparam int unsigned BUSY_MAX_US    = 900;
  localparam int unsigned BUSY_CYC       = BUSY_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned BUSY_MAX_CYC   = BUSY_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned ERASE_WAIT_US  = 8000;
  localparam int unsigned WRITE_WAIT_US  = 4000;
  localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_US * (CLK_HZ / 1000000);
  localparam int unsigned WRITE_WAIT_CYC = WRITE_WAIT_US * (CLK_HZ / 1000000);
  localparam logic [5:0]  FRAME_BITS     = 6'h20;

  typedef enum logic [3:0] {
    ISP_IDLE  = 4'b0001,
    ISP_ERASE = 4'b0010,
    ISP_AUTO  = 4'b0100,
    ISP_PROG  = 4'b1000
  } isp_wst_e;

  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } isp_bus_s;
endpackage

// ==== test/isp_access_sva.sv ====
// Port assertions for the programming access block
`timescale 1ns/1ns
module isp_access_sva
  import isp_pkg::*;
#(parameter int unsigned BUSY_CYCLES = BUSY_CYC) (
  input wire logic CLK,                     // Clock
  input wire logic NRST,                    // Reset, low
  input wire logic RESET_PIN,               // Reset pin level
  input wire logic SCK,                     // Serial clock
  input wire logic MISO,                    // Serial out
  input wire logic OE_N,                    // Output enable
  input wire logic WR_N,                    // Write strobe
  input wire logic DATA_OE,                 // Bus drive
  input wire logic READY_NOT_WORKING,       // Ready level
  input wire logic SERIAL_PROG_ENABLE_FUSE, // Serial fuse
  input wire logic PROG_ENABLED             // Serial enabled
);
  logic        sck_d, wr_d;
  logic [7:0]  fall_age;
  logic [31:0] wr_age;
  // Cycles since the last SCK fall and the last strobe fall, saturating
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sck_d <= 1'b0;
      wr_d <= 1'b1;
      fall_age <= 8'hFF;
      wr_age <= 32'h80000000;
    end else begin
      sck_d <= SCK;
      wr_d <= WR_N;
      fall_age <= (sck_d && !SCK) ? 8'h00 : fall_age + {7'h00, ~&fall_age};
      wr_age <= (wr_d && !WR_N) ? 32'h0 : wr_age + {31'h0, ~wr_age[31]};
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  a_oe_on: assert property ($fell(OE_N) |-> ##[1:6] DATA_OE)
    else $error("bus drive late after output enable");
  a_oe_off: assert property ($rose(OE_N) |-> ##[1:6] !DATA_OE)
    else $error("bus still driven after output enable");
  a_busy_start: assert property (
    $rose(WR_N) && wr_age + 8 < BUSY_CYCLES |-> ##[1:6] !READY_NOT_WORKING)
    else $error("no busy pulse after strobe");
  a_busy_cause: assert property (
    $fell(READY_NOT_WORKING) |-> WR_N && wr_age <= BUSY_CYCLES + 2)
    else $error("busy pulse without strobe");
  a_busy_len: assert property (
    $rose(READY_NOT_WORKING) |->
      wr_age >= BUSY_CYCLES && wr_age <= BUSY_CYCLES + 4)
    else $error("busy pulse length wrong");
  a_busy_hidden: assert property (
    $past(WR_N, 3) == 1'b0 |-> READY_NOT_WORKING)
    else $error("busy shown while strobe held low");
  a_enable_cause: assert property (
    $rose(PROG_ENABLED) |-> !SERIAL_PROG_ENABLE_FUSE && !RESET_PIN)
    else $error("serial enable without fuse or pin");
  a_enable_drop: assert property ($rose(RESET_PIN) |-> ##[1:6] !PROG_ENABLED)
    else $error("serial enable kept with pin high");
  a_miso_fall: assert property ($changed(MISO) |-> fall_age <= 8'h07)
    else $error("serial out moved away from clock fall");
  c_enable: cover property ($rose(PROG_ENABLED));
  c_busy: cover property ($rose(READY_NOT_WORKING));
  c_drive: cover property ($rose(DATA_OE));
  c_hidden: cover property (!WR_N && wr_age == BUSY_CYCLES + 8);
endmodule
bind isp_access isp_access_sva #(.BUSY_CYCLES(BUSY_CYCLES)) u_sva (
  .CLK(CLK), .NRST(NRST), .RESET_PIN(RESET_PIN), .SCK(SCK), .MISO(MISO),
  .OE_N(OE_N), .WR_N(WR_N), .DATA_OE(DATA_OE),
  .READY_NOT_WORKING(READY_NOT_WORKING), .PROG_ENABLED(PROG_ENABLED),
  .SERIAL_PROG_ENABLE_FUSE(SERIAL_PROG_ENABLE_FUSE));

// ==== test/isp_prog_model.sv ====
// Serial programmer model sending 32-bit frames
`timescale 1ns/1ns
module isp_prog_model (
  input  wire logic CLK,  // Bench clock
  output logic      SCK,  // Serial clock
  output logic      MOSI, // Serial data out
  input  wire logic MISO  // Serial data in
);
  initial {SCK, MOSI} = 2'b00;
  task automatic xfer(input logic [31:0] w, output logic [7:0] r);
    r = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      MOSI <= w[i];
      repeat (3) @(negedge CLK);
      SCK <= 1'b1;
      repeat (5) @(negedge CLK);
      if (i < 8) r = {r[6:0], MISO};
      SCK <= 1'b0;
    end
    MOSI <= ~w[0];
    repeat (4) @(negedge CLK);
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the programming access block
`timescale 1ns/1ns
module tb;
  import isp_pkg::*;
  localparam int unsigned BC = 50;
  localparam int unsigned EC = 200;
  localparam int unsigned WC = 1200;
  localparam logic [7:0]  S0 = 8'h5A; // Arbitrary value
  localparam logic [7:0]  S1 = 8'hC3; // Arbitrary value
  localparam logic [7:0]  S2 = 8'h27; // Arbitrary value
  logic       clk = 1'b0, nrst = 1'b0, rpin = 1'b0, oe_n = 1'b1, wr_n = 1'b1;
  logic       bhs = 1'b0, xa = 1'b0, spf = 1'b0, rcf = 1'b1, h;
  logic       sck, mosi, miso, doe, rdy, pen;
  logic [7:0] din = 8'h00, rx, d, dout, e3f;
  logic [8:0] fa;
  logic [5:0] ea;
  int         fails = 0, comparisons = 0, n;
  always #10 clk = ~clk;
  isp_access #(.BUSY_CYCLES(BC), .ERASE_CYCLES(EC), .WRITE_CYCLES(WC),
    .SIG0(S0), .SIG1(S1), .SIG2(S2)) dut (
    .CLK(clk), .NRST(nrst), .RESET_PIN(rpin), .SCK(sck), .MOSI(mosi),
    .MISO(miso), .OE_N(oe_n), .WR_N(wr_n), .BYTE_HALF_SELECT(bhs),
    .XA_LOAD(xa), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .READY_NOT_WORKING(rdy), .SERIAL_PROG_ENABLE_FUSE(spf),
    .INTERNAL_RC_SELECT_FUSE(rcf), .PROG_ENABLED(pen));
  isp_prog_model pm (.CLK(clk), .SCK(sck), .MOSI(mosi), .MISO(miso));
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] sig_exp(input logic [1:0] a, input logic lk);
    return lk ? 8'h00 : a == 2'h0 ? S0 : a == 2'h1 ? S1 : S2;
  endfunction
  task automatic sx(input logic [31:0] w);
    pm.xfer(w, rx);
  endtask
  task automatic pload(input logic bs, input logic [7:0] v);
    bhs <= bs;
    din <= v;
    @(negedge clk) xa <= 1'b1;
    repeat (3) @(negedge clk);
    xa <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic pread(input logic bs, output logic [7:0] v);
    bhs <= bs;
    oe_n <= 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h00, doe}, 8'h01);
    v = dout;
    oe_n <= 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic probe(input logic lk);
    for (int a = 0; a < 3; a++) begin
      sx({OP_SIG_RD, 8'h00, 8'(a), 8'h00});
      chk(rx, sig_exp(2'(a), lk));
      pload(1'b0, PCMD_SIG_RD);
      pload(1'b1, 8'(a));
      pread(1'b0, d);
      if (!lk) chk(d, sig_exp(2'(a), 1'b0));
    end
    pload(1'b0, PCMD_FUSE_RD);
    pread(1'b1, d);
    chk(d & 8'hE1, {~lk, ~lk, spf, 4'h0, rcf});
  endtask
  initial begin
    void'($urandom(32'hB59F));
    rcf = 1'($urandom);
    repeat (16) @(negedge clk);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    chk({5'h00, pen, rdy, doe}, 8'h02);
    sx({OP_EE_WR, 16'h003E, 8'h5A});
    repeat (200) @(negedge clk);
    sx({OP_PRE, OP_PROG_EN, 16'($urandom)});
    chk({7'h00, pen}, 8'h01);
    sx({OP_EE_RD, 16'h003E, 8'h00});
    chk(rx, ERASED);
    for (int k = 0; k < 4; k++) begin
      ea = k > 1 ? EE_MAX_ADDR : 6'($urandom_range(61, 0));
      d = 8'($urandom_range(254, 1));
      sx({OP_EE_WR, 10'h000, ea, d});
      sx({OP_EE_RD, 10'h000, ea, 8'h00});
      chk(rx, POLL_VALUE_FIRST);
      repeat (300) @(negedge clk);
      sx({OP_EE_RD, 10'h000, ea, 8'h00});
      chk(rx, POLL_VALUE_SECOND);
      repeat (WC) @(negedge clk);
      sx({OP_EE_RD, 10'h000, ea, 8'h00});
      chk(rx, d);
    end
    e3f = d;
    $display("test eeprom done");
    for (int k = 0; k < 3; k++) begin
      fa = k == 0 ? FLASH_MAX_ADDR : 9'($urandom_range(240 * k, 240 * k - 170));
      h = 1'($urandom);
      d = 8'($urandom_range(254, 0));
      sx({OP_FL_WR, h, 10'h000, fa, d});
      sx({OP_FL_RD, h, 10'h000, fa, 8'h00});
      chk(rx, POLL_VALUE_SECOND);
      repeat (WC) @(negedge clk);
      sx({OP_FL_RD, h, 10'h000, fa, 8'h00});
      chk(rx, d);
      sx({OP_FL_RD, ~h, 10'h000, fa, 8'h00});
      chk(rx, ERASED);
    end
    sx({OP_EE_RD, 10'h000, EE_MAX_ADDR, 8'h00});
    chk(rx, e3f);
    $display("test flash done");
    probe(1'b0);
    sx({OP_PRE, LOCK_MASK, 16'h0000});
    repeat (WC) @(negedge clk);
    probe(1'b1);
    $display("test locks done");
    wr_n <= 1'b0;
    repeat (4) @(negedge clk);
    wr_n <= 1'b1;
    for (n = 0; n < 9 && rdy; n++) @(negedge clk);
    for (n = 0; n < 200 && !rdy; n++) @(negedge clk);
    chk({7'h00, n + 8 >= BC && n <= BC + 1}, 8'h01);
    wr_n <= 1'b0;
    n = 0;
    repeat (BC + 20) @(negedge clk) n += int'(!rdy);
    wr_n <= 1'b1;
    repeat (10) @(negedge clk) n += int'(!rdy);
    chk(8'(n), 8'h00);
    $display("test busy done");
    sx({OP_PRE, 3'b100, 5'($urandom), 16'($urandom)});
    repeat (EC + 20) @(negedge clk);
    rpin <= 1'b1;
    spf <= 1'b1;
    repeat (10) @(negedge clk);
    chk({7'h00, pen}, 8'h00);
    rpin <= 1'b0;
    repeat (10) @(negedge clk);
    sx({OP_PRE, OP_PROG_EN, 16'h0000});
    chk({7'h00, pen}, 8'h00);
    spf <= 1'b0;
    sx({OP_PRE, OP_PROG_EN, 16'h0000});
    chk({7'h00, pen}, 8'h01);
    sx({OP_EE_RD, 10'h000, EE_MAX_ADDR, 8'h00});
    chk(rx, ERASED);
    sx({OP_FL_RD, h, 10'h000, fa, 8'h00});
    chk(rx, ERASED);
    probe(1'b0);
    $display("test erase done");
    close_out;
  end
endmodule
